// >>> verilog/gpe_pin11.sv
// Purpose: Control, function routing and edge interrupt of one pin
// Assumes: Pin input synchronous to i_clk, Avalon-MM slave
// Notes: Clocks for the pin are made from i_clk by accumulators
`timescale 1ns/10ps
`include "gpe_defines.svh"
module gpe_pin11 #(
   parameter int LONG_DEB_CYC = `GPE_LONG_DEB_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [17:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_pin_in,
   output logic o_pin_out,
   output logic o_pin_oe,
   output logic o_pull_up,
   output logic o_pull_down,
   output logic o_io_supply_select,
   output logic [15:0] o_input_function,
   input wire gpe_pkg::gpe_src_s i_out_src,
   output logic o_irq
);
   localparam logic [17:0] ADDR_CTRL = 18'(`GPE_CTRL_IDX * 4);
   localparam logic [17:0] ADDR_STAT = 18'(`GPE_STAT_IDX * 4);
   localparam logic [17:0] ADDR_MASK = 18'(`GPE_MASK_IDX * 4);
   localparam logic [17:0] ADDR_LVL = 18'(`GPE_LVL_IDX * 4);
   localparam logic [17:0] ADDR_OUT = 18'(`GPE_OUT_IDX * 4);
   localparam logic [15:0] CTRL_RST = 16'(`GPE_CTRL_RST);
   localparam logic [15:0] CTRL_WMASK = 16'(`GPE_CTRL_WMASK);
   localparam gpe_pkg::gpe_cnt_t MODULUS = 24'(`GPE_CLK_HZ);
   // Toggling twice per period, so the step is twice the rate
   localparam gpe_pkg::gpe_cnt_t STEP_S = 24'(2 * `GPE_SLOW_HZ);
   localparam gpe_pkg::gpe_cnt_t STEP_F = 24'(2 * `GPE_FAST_HZ);
   localparam gpe_pkg::gpe_cnt_t DEB_LAST = 24'(LONG_DEB_CYC - 1);

   gpe_pkg::gpe_state_s q;
   gpe_pkg::gpe_state_s d;

   logic req;
   logic [15:0] wdata;
   logic [15:0] wmerge;
   logic long_deb;
   logic filt_chg;
   logic lvl_new;
   logic event_hit;
   logic src;
   logic drive_val;
   logic [31:0] rd_word;

   always_comb begin
      d = q;
      req = i_avs_read | i_avs_write;
      wdata = i_avs_writedata[15:0];
      wmerge = q.ctrl;
      if (i_avs_byteenable[0]) begin
         wmerge[7:0] = wdata[7:0];
      end
      if (i_avs_byteenable[1]) begin
         wmerge[15:8] = wdata[15:8];
      end
      wmerge = wmerge & CTRL_WMASK;

      // Long debounce applies to input codes 0, 4, 14 and 15
      case (q.ctrl.fn)
         4'h0: long_deb = 1'b1;
         4'h4: long_deb = 1'b1;
         4'he: long_deb = 1'b1;
         4'hf: long_deb = 1'b1;
         default: long_deb = 1'b0;
      endcase

      d.raw = i_pin_in;
      filt_chg = 1'b0;
      if (q.raw == q.filt) begin
         d.deb = '0;
      end else if (!long_deb || q.deb >= DEB_LAST) begin
         d.filt = q.raw;
         d.deb = '0;
         filt_chg = 1'b1;
      end else begin
         d.deb = q.deb + 24'h000001;
      end

      // Effective level: inverted when polarity is 0
      lvl_new = d.filt ^ ~q.ctrl.pol;
      event_hit = 1'b0;
      if (q.ctrl.ena && filt_chg) begin
         if (q.ctrl.edge_mode) begin
            event_hit = 1'b1;
         end else begin
            event_hit = lvl_new;
         end
      end

      // Input table only while the pin is an input
      d.fin = '0;
      if (q.ctrl.ena && q.ctrl.dir) begin
         d.fin[q.ctrl.fn] = lvl_new;
      end

      // Fractional dividers keep the average rate exact
      if (q.acc_s + STEP_S >= MODULUS) begin
         d.acc_s = q.acc_s + STEP_S - MODULUS;
         d.clk_s = ~q.clk_s;
      end else begin
         d.acc_s = q.acc_s + STEP_S;
      end
      if (q.acc_f + STEP_F >= MODULUS) begin
         d.acc_f = q.acc_f + STEP_F - MODULUS;
         d.clk_f = ~q.clk_f;
      end else begin
         d.acc_f = q.acc_f + STEP_F;
      end

      case (q.ctrl.fn)
         4'h0: src = q.out_lvl;
         4'h1: src = q.clk_s;
         4'h2: src = i_out_src.on_state;
         4'h3: src = i_out_src.sleep_state;
         4'h4: src = i_out_src.state_change;
         4'h8: src = i_out_src.voltage_scaling_request_one_done;
         4'h9: src = i_out_src.voltage_scaling_request_two_done;
         4'ha: src = i_out_src.ext_en1;
         4'hb: src = i_out_src.ext_en2;
         4'hc: src = i_out_src.sys_good;
         4'hd: src = i_out_src.converter_power_good;
         4'he: src = q.clk_f;
         4'hf: src = i_out_src.aux_reset;
         default: src = 1'b0;
      endcase
      drive_val = src ^ ~q.ctrl.pol;

      // Tri-stated unless enabled and configured as output
      if (!q.ctrl.ena || q.ctrl.dir) begin
         d.pin_o = 1'b0;
         d.pin_oe = 1'b0;
      end else if (q.ctrl.od) begin
         d.pin_o = 1'b0;
         d.pin_oe = ~drive_val;
      end else begin
         d.pin_o = drive_val;
         d.pin_oe = 1'b1;
      end

      rd_word = '0;
      case (i_avs_address)
         ADDR_CTRL: rd_word[15:0] = q.ctrl;
         ADDR_STAT: rd_word[0] = q.stat;
         ADDR_MASK: rd_word[0] = q.mask;
         ADDR_LVL: rd_word[3:0] = {q.pin_o, q.pin_oe, q.filt, q.raw};
         ADDR_OUT: rd_word[0] = q.out_lvl;
         default: rd_word = '0;
      endcase

      case (q.bus)
         gpe_pkg::BUS_IDLE: begin
            d.wreq = 1'b1;
            if (req) begin
               d.bus = gpe_pkg::BUS_ACK;
               d.wreq = 1'b0;
               d.rdata = i_avs_read ? rd_word : 32'h00000000;
            end
         end
         gpe_pkg::BUS_ACK: begin
            // A write lands only at the edge that sees waitrequest low
            if (i_avs_write) begin
               case (i_avs_address)
                  ADDR_CTRL: d.ctrl = wmerge;
                  ADDR_STAT: begin
                     if (i_avs_byteenable[0] && wdata[0]) begin
                        d.stat = 1'b0;
                     end
                  end
                  ADDR_MASK: begin
                     if (i_avs_byteenable[0]) begin
                        d.mask = wdata[0];
                     end
                  end
                  ADDR_OUT: begin
                     if (i_avs_byteenable[0]) begin
                        d.out_lvl = wdata[0];
                     end
                  end
                  default: d.ctrl = q.ctrl;
               endcase
            end
            // One idle cycle lets the master drop the request
            d.bus = gpe_pkg::BUS_IDLE;
            d.wreq = 1'b1;
         end
         default: begin
            d.bus = gpe_pkg::BUS_IDLE;
            d.wreq = 1'b1;
         end
      endcase

      // Set wins over a clear in the same cycle
      if (event_hit) begin
         d.stat = 1'b1;
      end
      d.irq = d.stat & d.mask;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
         q.bus <= gpe_pkg::BUS_IDLE;
         q.wreq <= 1'b1;
         q.ctrl <= gpe_pkg::gpe_ctrl_s'(CTRL_RST);
      end else begin
         q <= d;
      end
   end

   assign o_avs_readdata = q.rdata;
   assign o_avs_waitrequest = q.wreq;
   assign o_pin_out = q.pin_o;
   assign o_pin_oe = q.pin_oe;
   // Reserved pull code 11 applies no resistor
   assign o_pull_up = (q.ctrl.pull == 2'h2);
   assign o_pull_down = (q.ctrl.pull == 2'h1);
   assign o_io_supply_select = q.ctrl.supply;
   assign o_input_function = q.fin;
   assign o_irq = q.irq;
endmodule : gpe_pin11

// >>> verilog/gpe_defines.svh
// Purpose: Offsets, field positions, reset values, timing counts
// Assumes: 32-bit Avalon words, byte address is four times index
// Notes: Definitions only
`ifndef GPE_DEFINES_SVH
`define GPE_DEFINES_SVH
`define GPE_CTRL_IDX 16'h4042
`define GPE_STAT_IDX 16'h4050
`define GPE_MASK_IDX 16'h4051
`define GPE_LVL_IDX 16'h4052
`define GPE_OUT_IDX 16'h4053
`define GPE_CTRL_RST 16'ha400
`define GPE_CTRL_WMASK 16'hfe8f
`define GPE_BIT_DIR 15
`define GPE_BIT_PULL_HI 14
`define GPE_BIT_PULL_LO 13
`define GPE_BIT_EDGE 12
`define GPE_BIT_SUPPLY 11
`define GPE_BIT_POL 10
`define GPE_BIT_OD 9
`define GPE_BIT_ENA 7
`define GPE_BIT_FN_HI 3
`define GPE_BIT_FN_LO 0
`define GPE_CLK_HZ 10000000
`define GPE_SLOW_HZ 32768
`define GPE_FAST_HZ 2000000
`define GPE_LONG_DEB_US 30000
`define GPE_LONG_DEB_CYC (`GPE_LONG_DEB_US * (`GPE_CLK_HZ / 1000000))
`endif

// >>> verilog/gpe_pkg.sv
// Purpose: Types shared by the pin control block
// Assumes: Field layout mirrors the control register
// Notes: Debounce counter is 24 bits wide
package gpe_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } gpe_bus_e;
   typedef struct packed {
      logic dir;
      logic [1:0] pull;
      logic edge_mode;
      logic supply;
      logic pol;
      logic od;
      logic rsv8;
      logic ena;
      logic [2:0] rsv4;
      logic [3:0] fn;
   } gpe_ctrl_s;
   typedef struct packed {
      logic on_state;
      logic sleep_state;
      logic state_change;
      logic voltage_scaling_request_one_done;
      logic voltage_scaling_request_two_done;
      logic ext_en1;
      logic ext_en2;
      logic sys_good;
      logic converter_power_good;
      logic aux_reset;
   } gpe_src_s;
   typedef logic [23:0] gpe_cnt_t;
   typedef struct packed {
      gpe_bus_e bus;
      logic wreq;
      logic [31:0] rdata;
      gpe_ctrl_s ctrl;
      logic out_lvl;
      logic stat;
      logic mask;
      logic irq;
      logic raw;
      logic filt;
      gpe_cnt_t deb;
      gpe_cnt_t acc_s;
      gpe_cnt_t acc_f;
      logic clk_s;
      logic clk_f;
      logic pin_o;
      logic pin_oe;
      logic [15:0] fin;
   } gpe_state_s;
endpackage : gpe_pkg

// >>> verification/gpe_pin11_monitor.sv
// Purpose: Port-level checks for the pin control block
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound from the bench top onto the design
`timescale 1ns/10ps
module gpe_pin11_monitor (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic o_pin_oe,
   input wire logic o_pull_up,
   input wire logic o_pull_down,
   input wire logic o_io_supply_select,
   input wire logic [15:0] o_input_function,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_rst_vals;
      $fell(i_rst) |-> o_pull_down && !o_pull_up && !o_io_supply_select
         && !o_pin_oe && o_input_function == 16'h0000 && !o_irq;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("Pin outputs wrong after reset");
   property p_pull_excl; !(o_pull_up && o_pull_down); endproperty
   a_pull_excl: assert property (p_pull_excl)
      else $error("Both pulls on");
   property p_drive_dir; o_pin_oe |-> o_input_function == 16'h0000; endproperty
   a_drive_dir: assert property (p_drive_dir)
      else $error("Input function active while driving");
   property p_fn_onehot; $onehot0(o_input_function); endproperty
   a_fn_onehot: assert property (p_fn_onehot)
      else $error("Several input functions at once");
   property p_ans_once; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
   a_ans_once: assert property (p_ans_once)
      else $error("Answer longer than one cycle");
   property p_ans_cause; !o_avs_waitrequest |-> i_avs_read || i_avs_write;
   endproperty
   a_ans_cause: assert property (p_ans_cause)
      else $error("Answer without request");
   property p_ans_bound;
      (i_avs_read || i_avs_write) && o_avs_waitrequest
         |-> ##[0:2] !o_avs_waitrequest;
   endproperty
   a_ans_bound: assert property (p_ans_bound)
      else $error("Request not answered in time");
   // Status and mask only drop on a write, so the level must hold otherwise
   property p_irq_hold; o_irq && !i_avs_write |=> o_irq; endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("Interrupt dropped without a write");
endmodule : gpe_pin11_monitor

// >>> verification/gpe_pin_model.sv
// Purpose: Board side of the pin: driver, pulls and wire level
// Assumes: Bench sets drive enable and level after clock edges
// Notes: Floating wire toggles so an unknown cannot pass as a level
`timescale 1ns/10ps
module gpe_pin_model (
   input wire logic i_clk,
   input wire logic i_drv_en,
   input wire logic i_drv_lvl,
   input wire logic i_pin_out,
   input wire logic i_pin_oe,
   input wire logic i_pull_up,
   input wire logic i_pull_down,
   output logic o_pin
);
   logic float_q = 1'b0;
   always @(posedge i_clk) float_q <= ~float_q;
   always_comb begin
      if (i_pin_oe) o_pin = i_pin_out;
      else if (i_drv_en) o_pin = i_drv_lvl;
      else if (i_pull_up || i_pull_down) o_pin = i_pull_up;
      else o_pin = float_q;
   end
endmodule : gpe_pin_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the pin control block
// Assumes: Long debounce shortened to 8 cycles
// Notes: Output codes from a table, awkward cases by hand
`timescale 1ns/10ps
`include "gpe_defines.svh"
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic drv_en = 1'b0;
   logic drv_lvl = 1'b0;
   logic [17:0] adr = 18'h00000;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] rdat, q;
   logic wreq, pout, poe, pu, pd, sup, irq, pin;
   logic [15:0] fin;
   gpe_pkg::gpe_src_s src = '0;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   logic [3:0] ofn [10] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
      4'hd, 4'hf};
   always #50 clk = ~clk;
   gpe_pin11 #(.LONG_DEB_CYC(8)) i_dut (.i_clk(clk), .i_rst(rst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_pin_in(pin), .o_pin_out(pout),
      .o_pin_oe(poe), .o_pull_up(pu), .o_pull_down(pd),
      .o_io_supply_select(sup), .o_input_function(fin), .i_out_src(src),
      .o_irq(irq));
   gpe_pin_model i_pin (.i_clk(clk), .i_drv_en(drv_en), .i_drv_lvl(drv_lvl),
      .i_pin_out(pout), .i_pin_oe(poe), .i_pull_up(pu), .i_pull_down(pd),
      .o_pin(pin));
   task print_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   // Request held until waitrequest is sampled low; timeout ends a hang
   task bus(input logic w, input logic [15:0] i, input logic [31:0] d);
      @(posedge clk);
      adr <= {i, 2'b00};
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task oc(input logic [15:0] c, input logic [1:0] e);
      bus(1'b1, `GPE_CTRL_IDX, {16'h0000, c});
      tick(2);
      chk({pout & poe, poe}, e);
   endtask : oc
   task ev(input logic lvl, input logic e);
      drv_lvl <= lvl;
      tick(4);
      chk(irq, e);
      bus(1'b1, `GPE_STAT_IDX, 32'h1);
      tick(2);
      chk(irq, 1'b0);
   endtask : ev
   task rises(input logic [15:0] c, input int k);
      logic last;
      bus(1'b1, `GPE_CTRL_IDX, {16'h0000, c});
      last = pout;
      n = 0;
      repeat (k) begin
         @(posedge clk);
         if (pout === 1'b1 && last === 1'b0) n++;
         last = pout;
      end
   endtask : rises
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      tick(16);
      rst <= 1'b0;
      tick(1);
      bus(1'b0, `GPE_CTRL_IDX, 32'h0);
      chk(q, 32'h0000a400);
      chk({pu, pd, sup, poe}, 4'b0100);
      bus(1'b0, 16'h4060, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, `GPE_CTRL_IDX, 32'hffffffff);
      bus(1'b0, `GPE_CTRL_IDX, 32'h0);
      chk(q, 32'h0000fe8f);
      chk(sup, 1'b1);
      bus(1'b1, `GPE_CTRL_IDX, 32'h4000);
      tick(1);
      chk({pu, pd}, 2'b10);
      $display("Test registers done");
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, `GPE_CTRL_IDX, {28'h0000048, ofn[i]});
         for (int v = 0; v < 2; v++) begin
            src <= gpe_pkg::gpe_src_s'(v ? 10'h200 >> i : ~(10'h200 >> i));
            tick(3);
            chk({pout, poe}, {v[0], 1'b1});
         end
      end
      $display("Test output table done");
      src <= gpe_pkg::gpe_src_s'(10'h3ff);
      oc(16'h0485, 2'b01);
      bus(1'b1, `GPE_OUT_IDX, 32'h1);
      oc(16'h0480, 2'b11);
      oc(16'h0680, 2'b00);
      bus(1'b1, `GPE_OUT_IDX, 32'h0);
      oc(16'h0680, 2'b01);
      oc(16'h0080, 2'b11);
      oc(16'h0400, 2'b00);
      rises(16'h0481, 10000);
      chk(n >= 32 && n <= 33, 1'b1);
      rises(16'h048e, 1000);
      chk(n >= 199 && n <= 201, 1'b1);
      $display("Test output cases done");
      drv_en <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         drv_lvl <= 1'b0;
         tick(12);
         bus(1'b1, `GPE_CTRL_IDX, 32'h8480 | c);
         drv_lvl <= 1'b1;
         tick(4);
         chk(fin, (c inside {0, 4, 14, 15}) ? 32'h0 : 32'h1 << c);
         tick(10);
         chk(fin, 32'h1 << c);
      end
      $display("Test input table done");
      drv_lvl <= 1'b0;
      tick(12);
      bus(1'b1, `GPE_CTRL_IDX, 32'h8481);
      bus(1'b1, `GPE_MASK_IDX, 32'h1);
      bus(1'b1, `GPE_STAT_IDX, 32'h1);
      ev(1'b1, 1'b1);
      ev(1'b0, 1'b0);
      bus(1'b1, `GPE_CTRL_IDX, 32'h9481);
      ev(1'b1, 1'b1);
      ev(1'b0, 1'b1);
      bus(1'b1, `GPE_CTRL_IDX, 32'h8081);
      ev(1'b1, 1'b0);
      chk(fin, 32'h0);
      ev(1'b0, 1'b1);
      chk(fin, 32'h2);
      bus(1'b1, `GPE_MASK_IDX, 32'h0);
      drv_lvl <= 1'b1;
      tick(4);
      drv_lvl <= 1'b0;
      tick(4);
      bus(1'b0, `GPE_STAT_IDX, 32'h0);
      chk({q[0], irq}, 2'b10);
      $display("Test interrupt done");
      print_verdict();
   end
endmodule : tb_top
bind gpe_pin11 gpe_pin11_monitor i_mon (.i_clk(i_clk), .i_rst(i_rst),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .o_pin_oe(o_pin_oe),
   .o_pull_up(o_pull_up), .o_pull_down(o_pull_down),
   .o_io_supply_select(o_io_supply_select),
   .o_input_function(o_input_function), .o_irq(o_irq));
